// ===== clt_pkg.sv
// Shared constants and types of the control link transport engine
`default_nettype none
package clt_pkg;

   // ==========================================
   // Sequence numbering
   localparam int unsigned CLT_SEQ_W  = 10;
   localparam logic [9:0]  CLT_SEQ_MAX = 10'h3e7;
   localparam logic [9:0]  CLT_ISN     = 10'h000;
   localparam logic [3:0]  CLT_REP_TX  = 4'h0;

   typedef logic [CLT_SEQ_W-1:0] clt_seq_t;

   typedef enum logic [1:0] {
      CLT_NO_CODE,
      CLT_CONNECTION_OPEN_CODE,
      CLT_CONNECTION_CLOSE_CODE
   } clt_flag_t;

   typedef struct packed {
      clt_seq_t   send_sequence_number;
      clt_seq_t   acknowledge_sequence_number;
      logic [3:0] repetition_field;
      clt_flag_t  flag;
      logic       ack_valid;
      logic       has_lp;
      logic [15:0] lp;
   } clt_pkt_t;

   typedef enum logic [3:0] {
      CLT_CLOSED, CLT_OPEN_SEND, CLT_OPEN_SENT, CLT_ACC_SEND,
      CLT_ACC_WAIT, CLT_OPEN_ACK, CLT_OPEN, CLT_CLOSE_SEND,
      CLT_CLOSE_SENT, CLT_CLOSE_REPLY, CLT_CLOSE_ACC, CLT_CLOSE_ACK
   } clt_state_t;

   // ==========================================
   // Register map
   localparam logic [7:0] CLT_OFF_CTRL    = 8'h00;
   localparam logic [7:0] CLT_OFF_STATUS  = 8'h04;
   localparam logic [7:0] CLT_OFF_TXDATA  = 8'h08;
   localparam logic [7:0] CLT_OFF_RXDATA  = 8'h0c;
   localparam logic [7:0] CLT_OFF_SEQ     = 8'h10;
   localparam logic [7:0] CLT_OFF_TIMEOUT = 8'h14;

   localparam int unsigned CLT_CTRL_OPEN_BIT  = 0;
   localparam int unsigned CLT_CTRL_CLOSE_BIT = 1;
   localparam int unsigned CLT_ST_UNA_BIT     = 4;
   localparam int unsigned CLT_ST_TXQ_BIT     = 5;
   localparam int unsigned CLT_ST_RXQ_BIT     = 6;
   localparam int unsigned CLT_ST_ACK_BIT     = 7;
   localparam int unsigned CLT_RX_VALID_BIT   = 16;
   localparam int unsigned CLT_SEQ_EXP_LSB    = 16;

   // ==========================================
   // Timing
   localparam int unsigned CLT_CLK_MHZ    = 40;
   localparam int unsigned CLT_TIMEOUT_US = 100;
   localparam logic [15:0] CLT_TIMEOUT_CYC = 16'(CLT_TIMEOUT_US * CLT_CLK_MHZ);

endpackage : clt_pkg
`default_nettype wire

// ===== clt_seq_inc.sv
// Modulo-1000 increment of a sequence number
`timescale 1ns/100ps
`default_nettype none
module clt_seq_inc (
   input  wire clt_pkg::clt_seq_t seq,
   output var  clt_pkg::clt_seq_t seq_inc
);
   always_comb begin
      if (seq == clt_pkg::CLT_SEQ_MAX) begin
         seq_inc = '0;
      end else begin
         seq_inc = seq + 10'h001;
      end
   end
endmodule : clt_seq_inc
`default_nettype wire

// ===== clt_buf2.sv
// Two-entry buffer with valid/ready on both sides, registered head
`timescale 1ns/100ps
`default_nettype none
module clt_buf2 #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   typedef struct packed {
      logic         v0;
      logic         v1;
      logic [W-1:0] d0;
      logic [W-1:0] d1;
   } clt_buf_st_t;

   clt_buf_st_t s_reg;
   clt_buf_st_t s_next;

   assign in_ready  = ~s_reg.v1;
   assign out_valid = s_reg.v0;
   assign out_data  = s_reg.d0;

   always_comb begin
      s_next = s_reg;
      if (out_ready && s_reg.v0) begin
         s_next.d0 = s_reg.d1;
         s_next.v0 = s_reg.v1;
         s_next.v1 = 1'b0;
      end
      if (in_valid && !s_reg.v1) begin
         if (!s_next.v0) begin
            s_next.d0 = in_data;
            s_next.v0 = 1'b1;
         end else begin
            s_next.d1 = in_data;
            s_next.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end
endmodule : clt_buf2
`default_nettype wire

// ===== clt_engine.sv
// Control link transport connection engine with APB registers
// Functional notes
// R1 - An open request carries the open code, any sequence number, an invalid acknowledge and no logical packet.
// R2 - An accept carries the open code, any sequence number, a valid acknowledge of the request and no logical packet.
// R3 - The initiator acknowledges the accept and the connection counts as open once that acknowledge is sent.
// R4 - Either end may ask to close an open connection with a packet carrying the close code.
// R5 - A close packet counts as payload, advances the send number and is otherwise coded as on an open connection.
// R6 - The accepting end answers a close with the close code, the requester acknowledges it, then the link is closed.
// R7 - An end with data still to send refuses a close by sending an ordinary packet without the close code.
// R8 - After a refusal the requester acknowledges the data and sets the close code again in that acknowledge.
// R9 - Packets carrying data are exchanged only while the connection is open.
// R10 - Every packet carrying a logical packet is acknowledged by the receiver.
// R11 - A receiver may carry its own logical packet in the packet that acknowledges.
// R12 - One acknowledge may cover several packets and carries the send number expected next.
// R13 - The repetition field is always sent as zero.
// R14 - Sequence numbers reveal lost packets and the interrupted packet is sent again automatically.
// R15 - An unacknowledged packet is sent again when no acknowledge arrives within the time-out.
// R16 - The send number advances by one only for payload, wrapping from 999 to 0; the code also advances it once the open request or the accept is acknowledged.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module clt_engine (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   tx_valid,
   output clt_pkg::clt_pkt_t      tx_pkt,
   input  wire logic              tx_ready,
   input  wire logic              rx_valid,
   input  wire clt_pkg::clt_pkt_t rx_pkt
);

   // ==========================================
   // State
   typedef struct packed {
      clt_pkg::clt_state_t st;
      clt_pkg::clt_seq_t   next_seq;
      clt_pkg::clt_seq_t   exp_seq;
      logic                need_ack;
      logic                una_v;
      clt_pkg::clt_pkt_t   una;
      logic                rtx;
      logic [15:0]         tmr;
      logic [15:0]         tmo;
      logic                txq_v;
      logic [15:0]         txq;
      logic                rxq_v;
      logic [15:0]         rxq;
      logic                open_req;
      logic                close_req;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } clt_core_t;

   clt_core_t s_reg;
   clt_core_t s_next;

   clt_pkg::clt_seq_t next_inc;
   clt_pkg::clt_seq_t exp_inc;
   clt_pkg::clt_seq_t rx_inc;
   clt_pkg::clt_pkt_t pkt;
   logic              send;
   logic              bin_ready;
   logic              in_order;
   logic              carries;

   clt_seq_inc u_inc_next (
      .seq     (s_reg.next_seq),
      .seq_inc (next_inc)
   );

   clt_seq_inc u_inc_exp (
      .seq     (s_reg.exp_seq),
      .seq_inc (exp_inc)
   );

   clt_seq_inc u_inc_rx (
      .seq     (rx_pkt.send_sequence_number),
      .seq_inc (rx_inc)
   );

   // Stalled link fills this, and send waits on bin_ready
   clt_buf2 #(
      .W ($bits(clt_pkg::clt_pkt_t))
   ) u_txbuf (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (send),
      .in_data   (pkt),
      .in_ready  (bin_ready),
      .out_valid (tx_valid),
      .out_data  (tx_pkt),
      .out_ready (tx_ready)
   );

   assign prdata  = s_reg.prdata;
   assign pready  = s_reg.pready;
   assign pslverr = s_reg.pslverr;

   assign carries  = rx_pkt.has_lp || (rx_pkt.flag == clt_pkg::CLT_CONNECTION_CLOSE_CODE);
   assign in_order = (rx_pkt.send_sequence_number == s_reg.exp_seq) && !(rx_pkt.has_lp && s_reg.rxq_v);

   always_comb begin
      s_next = s_reg;
      send   = 1'b0;
      pkt    = '0;
      pkt.repetition_field            = clt_pkg::CLT_REP_TX; // R13
      pkt.send_sequence_number        = s_reg.next_seq;
      pkt.acknowledge_sequence_number = s_reg.exp_seq; // R12
      pkt.ack_valid                   = 1'b1;
      pkt.flag                        = clt_pkg::CLT_NO_CODE;

      // ==========================================
      // APB slave, one wait-free access phase
      s_next.pready = psel && !penable;
      if (psel && !penable) begin
         s_next.pslverr = 1'b0;
         s_next.prdata  = '0;
         unique case (paddr)
            clt_pkg::CLT_OFF_CTRL: begin
               s_next.prdata[clt_pkg::CLT_CTRL_OPEN_BIT]  = s_reg.open_req;
               s_next.prdata[clt_pkg::CLT_CTRL_CLOSE_BIT] = s_reg.close_req;
            end
            clt_pkg::CLT_OFF_STATUS: begin
               s_next.prdata[3:0] = s_reg.st;
               s_next.prdata[clt_pkg::CLT_ST_UNA_BIT] = s_reg.una_v;
               s_next.prdata[clt_pkg::CLT_ST_TXQ_BIT] = s_reg.txq_v;
               s_next.prdata[clt_pkg::CLT_ST_RXQ_BIT] = s_reg.rxq_v;
               s_next.prdata[clt_pkg::CLT_ST_ACK_BIT] = s_reg.need_ack;
               s_next.pslverr = pwrite;
            end
            clt_pkg::CLT_OFF_TXDATA: begin
               // Full holding word refuses the write
               s_next.prdata[15:0] = s_reg.txq;
               s_next.pslverr      = pwrite && s_reg.txq_v;
            end
            clt_pkg::CLT_OFF_RXDATA: begin
               s_next.prdata[15:0] = s_reg.rxq;
               s_next.prdata[clt_pkg::CLT_RX_VALID_BIT] = s_reg.rxq_v;
               s_next.pslverr = pwrite;
            end
            clt_pkg::CLT_OFF_SEQ: begin
               s_next.prdata[9:0] = s_reg.next_seq;
               s_next.prdata[clt_pkg::CLT_SEQ_EXP_LSB +: 10] = s_reg.exp_seq;
               s_next.pslverr = pwrite;
            end
            clt_pkg::CLT_OFF_TIMEOUT: begin
               s_next.prdata[15:0] = s_reg.tmo;
            end
            default: begin
               s_next.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && s_reg.pready && !s_reg.pslverr) begin
         if (pwrite) begin
            unique case (paddr)
               clt_pkg::CLT_OFF_CTRL: begin
                  if (pwdata[clt_pkg::CLT_CTRL_OPEN_BIT]) begin
                     s_next.open_req = 1'b1;
                  end
                  if (pwdata[clt_pkg::CLT_CTRL_CLOSE_BIT]) begin
                     s_next.close_req = 1'b1;
                  end
               end
               clt_pkg::CLT_OFF_TXDATA: begin
                  s_next.txq   = pwdata[15:0];
                  s_next.txq_v = 1'b1;
               end
               clt_pkg::CLT_OFF_TIMEOUT: begin
                  s_next.tmo = pwdata[15:0];
               end
               default: begin
               end
            endcase
         end else if (paddr == clt_pkg::CLT_OFF_RXDATA) begin
            s_next.rxq_v = 1'b0;
         end
      end

      // ==========================================
      // Time-out on the packet awaiting its answer
      if (s_reg.una_v && s_reg.tmr != 16'h0000) begin
         s_next.tmr = s_reg.tmr - 16'h0001;
         if (s_reg.tmr == 16'h0001) begin
            s_next.rtx = 1'b1; // R15
         end
      end

      // ==========================================
      // Transmit side
      if (bin_ready) begin
         if (s_reg.rtx && s_reg.una_v) begin
            pkt = s_reg.una; // R14 R15
            if (s_reg.una.ack_valid) begin
               pkt.acknowledge_sequence_number = s_reg.exp_seq;
            end
            send       = 1'b1;
            s_next.rtx = 1'b0;
            s_next.tmr = s_reg.tmo;
         end else begin
            unique case (s_reg.st)
               clt_pkg::CLT_CLOSED: begin
                  if (s_reg.open_req) begin
                     s_next.open_req = 1'b0;
                     s_next.st       = clt_pkg::CLT_OPEN_SEND;
                  end
               end
               clt_pkg::CLT_OPEN_SEND: begin
                  pkt.flag      = clt_pkg::CLT_CONNECTION_OPEN_CODE; // R1
                  pkt.ack_valid = 1'b0;
                  send          = 1'b1;
                  s_next.st     = clt_pkg::CLT_OPEN_SENT;
               end
               clt_pkg::CLT_ACC_SEND: begin
                  pkt.flag  = clt_pkg::CLT_CONNECTION_OPEN_CODE; // R2
                  send      = 1'b1;
                  s_next.st = clt_pkg::CLT_ACC_WAIT;
               end
               clt_pkg::CLT_OPEN_ACK: begin
                  send      = 1'b1;
                  s_next.st = clt_pkg::CLT_OPEN; // R3
               end
               clt_pkg::CLT_CLOSE_SEND, clt_pkg::CLT_CLOSE_REPLY: begin
                  pkt.flag        = clt_pkg::CLT_CONNECTION_CLOSE_CODE; // R4 R6 R8
                  send            = 1'b1;
                  s_next.next_seq = next_inc; // R5 R16
                  s_next.st       = (s_reg.st == clt_pkg::CLT_CLOSE_SEND) ?
                                    clt_pkg::CLT_CLOSE_SENT : clt_pkg::CLT_CLOSE_ACC;
               end
               clt_pkg::CLT_CLOSE_ACK: begin
                  send      = 1'b1;
                  s_next.st = clt_pkg::CLT_CLOSED; // R6
               end
               clt_pkg::CLT_OPEN: begin
                  if (s_reg.close_req && !s_reg.txq_v && !s_reg.una_v) begin
                     s_next.close_req = 1'b0;
                     s_next.st        = clt_pkg::CLT_CLOSE_SEND; // R4
                  end else if (s_reg.txq_v && !s_reg.una_v) begin
                     pkt.has_lp      = 1'b1; // R9 R11
                     pkt.lp          = s_reg.txq;
                     send            = 1'b1;
                     s_next.txq_v    = 1'b0;
                     s_next.next_seq = next_inc; // R16
                  end else begin
                     send = s_reg.need_ack;
                  end
               end
               default: begin
                  send = s_reg.need_ack;
               end
            endcase
            // Anything that awaits an answer is kept for resending
            if (send && (pkt.has_lp || pkt.flag != clt_pkg::CLT_NO_CODE)) begin
               s_next.una   = pkt;
               s_next.una_v = 1'b1;
               s_next.tmr   = s_reg.tmo;
            end
         end
         if (send && pkt.ack_valid) begin
            s_next.need_ack = 1'b0; // R12
         end
      end

      // ==========================================
      // Receive side, after transmit so that its sets win
      if (rx_valid) begin
         unique case (s_reg.st)
            clt_pkg::CLT_CLOSED: begin
               if (rx_pkt.flag == clt_pkg::CLT_CONNECTION_OPEN_CODE && !rx_pkt.ack_valid) begin
                  s_next.exp_seq = rx_inc; // R2
                  s_next.st      = clt_pkg::CLT_ACC_SEND;
               end
            end
            clt_pkg::CLT_OPEN_SENT: begin
               if (rx_pkt.flag == clt_pkg::CLT_CONNECTION_OPEN_CODE && rx_pkt.ack_valid &&
                   rx_pkt.acknowledge_sequence_number == next_inc) begin
                  s_next.next_seq = rx_pkt.acknowledge_sequence_number;
                  s_next.exp_seq  = rx_inc;
                  s_next.una_v    = 1'b0;
                  s_next.rtx      = 1'b0;
                  s_next.st       = clt_pkg::CLT_OPEN_ACK; // R3
               end
            end
            clt_pkg::CLT_ACC_WAIT: begin
               if (rx_pkt.ack_valid && rx_pkt.flag == clt_pkg::CLT_NO_CODE &&
                   rx_pkt.acknowledge_sequence_number == next_inc) begin
                  s_next.next_seq = next_inc;
                  s_next.una_v = 1'b0;
                  s_next.rtx   = 1'b0;
                  s_next.st    = clt_pkg::CLT_OPEN;
               end
            end
            clt_pkg::CLT_OPEN, clt_pkg::CLT_CLOSE_SENT, clt_pkg::CLT_CLOSE_ACC: begin
               if (rx_pkt.ack_valid && s_reg.una_v) begin
                  if (rx_pkt.acknowledge_sequence_number == s_reg.next_seq) begin
                     s_next.una_v = 1'b0;
                     s_next.rtx   = 1'b0;
                     if (s_reg.st == clt_pkg::CLT_CLOSE_ACC) begin
                        s_next.st = clt_pkg::CLT_CLOSED; // R6
                     end
                  end else begin
                     s_next.rtx = 1'b1; // R14
                  end
               end
               if (carries) begin
                  s_next.need_ack = 1'b1; // R10
                  if (in_order) begin
                     s_next.exp_seq = exp_inc; // R12
                     if (rx_pkt.has_lp) begin
                        s_next.rxq   = rx_pkt.lp;
                        s_next.rxq_v = 1'b1;
                     end
                     if (s_reg.st == clt_pkg::CLT_CLOSE_SENT) begin
                        if (rx_pkt.flag == clt_pkg::CLT_CONNECTION_CLOSE_CODE) begin
                           s_next.st = clt_pkg::CLT_CLOSE_ACK; // R6
                        end else begin
                           s_next.st = clt_pkg::CLT_CLOSE_SEND; // R8
                        end
                     end else if (s_reg.st == clt_pkg::CLT_OPEN &&
                                  rx_pkt.flag == clt_pkg::CLT_CONNECTION_CLOSE_CODE &&
                                  !s_reg.txq_v && !s_next.una_v) begin
                        s_next.st = clt_pkg::CLT_CLOSE_REPLY; // R6 R7
                     end
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg          <= '0;
         s_reg.st       <= clt_pkg::CLT_CLOSED;
         s_reg.next_seq <= clt_pkg::CLT_ISN;
         s_reg.tmo      <= clt_pkg::CLT_TIMEOUT_CYC;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_close_out;
      ce && send && s_reg.st == clt_pkg::CLT_CLOSE_SEND;
   endsequence

   a_rep_zero: assert property (tx_valid |-> tx_pkt.repetition_field == 4'h0) // R13
      else $error("repetition field not zero");
   a_open_req_form: assert property (send && s_reg.st == clt_pkg::CLT_OPEN_SEND && !s_reg.rtx
      |-> pkt.flag == clt_pkg::CLT_CONNECTION_OPEN_CODE && !pkt.ack_valid && !pkt.has_lp) // R1
      else $error("bad open request");
   a_accept_form: assert property (send && s_reg.st == clt_pkg::CLT_ACC_SEND && !s_reg.rtx
      |-> pkt.ack_valid && !pkt.has_lp && pkt.acknowledge_sequence_number == s_reg.exp_seq) // R2
      else $error("bad accept packet");
   a_open_after_ack: assert property (ce && send && s_reg.st == clt_pkg::CLT_OPEN_ACK && !s_reg.rtx
      ##1 1'b1 |-> s_reg.st == clt_pkg::CLT_OPEN || $past(rx_valid)) // R3
      else $error("not open after final ack");
   a_close_seq_step: assert property (s_close_out |=> s_reg.next_seq == $past(next_inc)) // R5
      else $error("close did not advance sequence");
   a_data_when_open: assert property (send && pkt.has_lp |-> s_reg.st == clt_pkg::CLT_OPEN) // R9
      else $error("data outside open connection");
   a_ack_raised: assert property (ce && rx_valid && s_reg.st == clt_pkg::CLT_OPEN && rx_pkt.has_lp
      |=> s_reg.need_ack) // R10
      else $error("data not acknowledged");
   a_ack_cumul: assert property (send && pkt.ack_valid |-> pkt.acknowledge_sequence_number == s_reg.exp_seq) // R12
      else $error("ack number not next expected");
   a_refuse_close: assert property (ce && rx_valid && s_reg.st == clt_pkg::CLT_OPEN && (s_reg.txq_v ||
      (s_reg.una_v && rx_pkt.acknowledge_sequence_number != s_reg.next_seq))
      |=> s_reg.st != clt_pkg::CLT_CLOSE_REPLY) // R7
      else $error("close accepted with data pending");
   a_seq_wrap: assert property (ce && send && pkt.has_lp && s_reg.next_seq == 10'h3e7
      |=> s_reg.next_seq == 10'h000) // R16
      else $error("sequence did not wrap");

endmodule : clt_engine
`default_nettype wire

// ===== clt_peer.sv
// Far-end transport entity model for the control link
`timescale 1ns/100ps
`default_nettype none
module clt_peer (
   input  wire logic               clk,
   input  wire logic               tx_valid,
   input  wire clt_pkg::clt_pkt_t  tx_pkt,
   output logic                    tx_ready,
   output logic                    rx_valid,
   output clt_pkg::clt_pkt_t       rx_pkt
);
   // ==========================================
   // Link intake, optionally slow
   int unsigned       stall = 0;
   int unsigned       cnt = 0;
   clt_pkg::clt_pkt_t got[$];

   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_pkt   = '0;
   end

   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_pkt);
      end
      cnt <= cnt + 1;
      tx_ready <= (cnt % (stall + 1)) == 0;
   end

   // ==========================================
   // Packet building and sending
   function automatic clt_pkg::clt_pkt_t mk(input logic [9:0] s, input logic [9:0] a, input logic [1:0] f,
                                            input logic av, input logic hl, input logic [15:0] l);
      mk = '{s, a, 4'h0, clt_pkg::clt_flag_t'(f), av, hl, l};
   endfunction : mk

   // Idle bus shows the inverse, so a stale copy cannot pass for a packet
   task automatic send(input clt_pkg::clt_pkt_t p);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_pkt   <= p;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_pkt   <= ~p;
   endtask : send
endmodule : clt_peer
`default_nettype wire

// ===== control_link_transport_tb.sv
// Self-checking bench of the control link transport engine
`timescale 1ns/100ps
`default_nettype none
module control_link_transport_tb;
   logic                   clk, rst_n, psel, penable, pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata, prdata;
   logic                   pready, pslverr, tx_valid, tx_ready, rx_valid;
   clt_pkg::clt_pkt_t      tx_pkt, rx_pkt;
   int                     err_count = 0;
   int                     comparisons = 0;
   int                     cycles = 0;
   localparam logic [43:0] ALL = '1;
   localparam logic [43:0] NL  = 44'hfffffff0000;
   localparam logic [43:0] HDR = 44'h003ffff0000;
   localparam logic [43:0] FLG = 44'h00000ff0000;

   clt_engine dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_pkt(rx_pkt));
   clt_peer peer (.clk(clk), .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_pkt(rx_pkt));

   // ==========================================
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end

   // ==========================================
   // Checks and bus access
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [31:0] e, input logic ee);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      chk({31'h0, pslverr, prdata & m}, {31'h0, ee, e});
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : acc

   // Waits for the next packet from the engine and compares the masked fields
   task automatic take(input clt_pkg::clt_pkt_t e, input logic [43:0] m);
      int          n;
      logic [43:0] g;
      n = 0;
      while (peer.got.size() == 0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      g = (peer.got.size() > 0) ? peer.got.pop_front() : ~(e & m);
      chk(64'(g & m), 64'(e & m));
   endtask : take

   task automatic stop_test;
      $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // ==========================================
   // Main sequence
   initial begin
      rst_n   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      acc(1'b0, clt_pkg::CLT_OFF_STATUS, 32'h0, 32'hff, 32'h0, 1'b0);
      acc(1'b0, clt_pkg::CLT_OFF_TIMEOUT, 32'h0, 32'hffff, 32'h0fa0, 1'b0);
      acc(1'b0, 8'h18, 32'h0, 32'h0, 32'h0, 1'b1);
      acc(1'b1, clt_pkg::CLT_OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b1);
      acc(1'b1, clt_pkg::CLT_OFF_TIMEOUT, 32'h14, 32'h0, 32'h0, 1'b0);
      peer.stall = 3;
      acc(1'b1, clt_pkg::CLT_OFF_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
      take(peer.mk(10'h0, 10'h0, 2'h1, 1'b0, 1'b0, 16'h0), FLG);
      peer.send(peer.mk(10'h1c8, 10'h1, 2'h1, 1'b1, 1'b0, 16'h0));
      take(peer.mk(10'h0, 10'h1c9, 2'h0, 1'b1, 1'b0, 16'h0), HDR);
      acc(1'b0, clt_pkg::CLT_OFF_STATUS, 32'h0, 32'hf, 32'h6, 1'b0);
      acc(1'b0, clt_pkg::CLT_OFF_SEQ, 32'h0, 32'h03ff03ff, 32'h01c90001, 1'b0);
      peer.stall = 0;
      acc(1'b1, clt_pkg::CLT_OFF_TXDATA, 32'h1234, 32'h0, 32'h0, 1'b0);
      take(peer.mk(10'h1, 10'h1c9, 2'h0, 1'b1, 1'b1, 16'h1234), ALL);
      peer.send(peer.mk(10'h1c9, 10'h2, 2'h0, 1'b1, 1'b1, 16'habcd));
      take(peer.mk(10'h0, 10'h1ca, 2'h0, 1'b1, 1'b0, 16'h0), HDR);
      acc(1'b0, clt_pkg::CLT_OFF_RXDATA, 32'h0, 32'h1ffff, 32'h1abcd, 1'b0);
      acc(1'b0, clt_pkg::CLT_OFF_SEQ, 32'h0, 32'h03ff03ff, 32'h01ca0002, 1'b0);
      acc(1'b1, clt_pkg::CLT_OFF_TXDATA, 32'h5678, 32'h0, 32'h0, 1'b0);
      take(peer.mk(10'h2, 10'h1ca, 2'h0, 1'b1, 1'b1, 16'h5678), ALL);
      peer.send(peer.mk(10'h1ca, 10'h2, 2'h0, 1'b1, 1'b0, 16'h0));
      take(peer.mk(10'h2, 10'h1ca, 2'h0, 1'b1, 1'b1, 16'h5678), ALL);
      take(peer.mk(10'h2, 10'h1ca, 2'h0, 1'b1, 1'b1, 16'h5678), ALL);
      peer.send(peer.mk(10'h1ca, 10'h3, 2'h0, 1'b1, 1'b0, 16'h0));
      acc(1'b1, clt_pkg::CLT_OFF_TXDATA, 32'h0abc, 32'h0, 32'h0, 1'b0);
      take(peer.mk(10'h3, 10'h1ca, 2'h0, 1'b1, 1'b1, 16'h0abc), ALL);
      // Close arrives while the word is still unacknowledged
      peer.send(peer.mk(10'h1ca, 10'h3, 2'h2, 1'b1, 1'b0, 16'h0));
      take(peer.mk(10'h3, 10'h1cb, 2'h0, 1'b1, 1'b1, 16'h0abc), ALL);
      peer.send(peer.mk(10'h1cb, 10'h4, 2'h2, 1'b1, 1'b0, 16'h0));
      take(peer.mk(10'h4, 10'h1cc, 2'h2, 1'b1, 1'b0, 16'h0), NL);
      peer.send(peer.mk(10'h1cc, 10'h5, 2'h0, 1'b1, 1'b0, 16'h0));
      repeat (40) @(posedge clk);
      acc(1'b0, clt_pkg::CLT_OFF_STATUS, 32'h0, 32'hf, 32'h0, 1'b0);
      acc(1'b0, clt_pkg::CLT_OFF_SEQ, 32'h0, 32'h03ff03ff, 32'h01cc0005, 1'b0);
      peer.send(peer.mk(10'h2a, 10'h0, 2'h1, 1'b0, 1'b0, 16'h0));
      take(peer.mk(10'h5, 10'h2b, 2'h1, 1'b1, 1'b0, 16'h0), ALL);
      peer.send(peer.mk(10'h2b, 10'h6, 2'h0, 1'b1, 1'b0, 16'h0));
      acc(1'b1, clt_pkg::CLT_OFF_CTRL, 32'h2, 32'h0, 32'h0, 1'b0);
      take(peer.mk(10'h6, 10'h2b, 2'h2, 1'b1, 1'b0, 16'h0), ALL);
      peer.send(peer.mk(10'h2b, 10'h7, 2'h2, 1'b1, 1'b0, 16'h0));
      take(peer.mk(10'h7, 10'h2c, 2'h0, 1'b1, 1'b0, 16'h0), ALL);
      acc(1'b0, clt_pkg::CLT_OFF_SEQ, 32'h0, 32'h03ff03ff, 32'h002c0007, 1'b0);
      chk(64'(peer.got.size()), 64'h0);
      stop_test();
   end
endmodule : control_link_transport_tb
`default_nettype wire
